/* File: rtl/bcs_top.sv */
// Multi-channel buck sequencer: registers, soft start/stop, power good, overcurrent
`timescale 1ns/10ps
`default_nettype none

module bcs_top
	import bcs_pkg::*;
#(
	parameter int NCH               = bcs_pkg::NCH_DEF,
	parameter int OC_RESTART_CYCLES = bcs_pkg::OC_RESTART_CYC
)
(
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_rst_b,
	input  wire bcs_pkg::bcs_reg_req_t          i_reg_req,
	input  wire bcs_pkg::bcs_meas_t [NCH-1:0]   i_meas,
	output logic [15:0]                         o_reg_rdata,
	output logic                                o_reg_rvalid,
	output logic [NCH-1:0]                      o_pwm_hi,
	output logic [NCH-1:0]                      o_drv_en,
	output logic [NCH-1:0]                      o_pgood,
	output logic [NCH-1:0]                      o_oc_warn,
	output logic [NCH-1:0]                      o_oc_fault,
	output logic [2:0]                          o_osc_sel,
	output logic [NCH-1:0][6:0]                 o_ref_code
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0]           cur_limit_r [NCH];
	logic [15:0]          ss_timing_r [NCH];
	logic [15:0]          sd_timing_r [NCH];
	logic [7:0]           good_up_r   [NCH];
	logic [7:0]           good_lo_r   [NCH];
	logic [7:0]           good_dly_r  [NCH];
	logic [7:0]           duty_lim_r  [NCH];
	logic [7:0]           freq_r;
	logic [7:0]           follow_lo_r;
	logic [7:0]           follow_hi_r;
	logic [NCH-1:0]       chan_en_r;
	logic [2*FOLLOW_W*2-1:0] follow;
	logic [NCH-1:0]       fault_det;
	logic [NCH-1:0]       trig;
	logic [3:0]           page;
	logic [3:0]           idx;
	logic                 misc_wr;
	logic                 freq_ok;
	logic [15:0]          rdata_nxt;

	assign page    = i_reg_req.addr[7:4];
	assign idx     = i_reg_req.addr[3:0];
	assign misc_wr = i_reg_req.wr && (page == PG_MISC);
	assign follow  = {follow_hi_r, follow_lo_r};
	assign freq_ok = freq_valid(freq_r[FREQ_OSC_LSB +: 3], freq_r[FREQ_DIV_LSB +: 3]);

	// ----------------------------------------------------------------
	// Chip-wide registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			freq_r      <= RST_FREQ;
			follow_lo_r <= RST_FOLLOW;
			follow_hi_r <= RST_FOLLOW;
			chan_en_r   <= '0;
		end
		else if (misc_wr)
		begin
			case (idx)
				IX_FREQ:      freq_r      <= i_reg_req.wdata[7:0];
				IX_FOLLOW_LO: follow_lo_r <= i_reg_req.wdata[7:0];
				IX_FOLLOW_HI: follow_hi_r <= i_reg_req.wdata[7:0];
				IX_CHAN_EN:   chan_en_r   <= i_reg_req.wdata[NCH-1:0];
				default:      ;
			endcase
		end
	end

	// Oscillator selection leaves the chip as a code; the clock tree acts on it
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			o_osc_sel <= RST_FREQ[FREQ_OSC_LSB +: 3];
		else
			o_osc_sel <= freq_r[FREQ_OSC_LSB +: 3];
	end

	// ----------------------------------------------------------------
	// Fault fan-out to follower channels
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int t = 0; t < NCH; t++)
		begin
			trig[t] = fault_det[t];
			for (int f = 0; f < NCH; f++)
				trig[t] = trig[t] | (fault_det[f] & follow[f*FOLLOW_W + t]);
		end
	end

	// ----------------------------------------------------------------
	// Per-channel logic
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		bcs_state_t       st_r;
		bcs_state_t       st_nxt;
		logic [CNT_W-1:0] cnt_r;
		logic [CNT_W-1:0] cnt_nxt;
		logic [CNT_W-1:0] ss_dly_cyc;
		logic [CNT_W-1:0] ss_hold_cyc;
		logic [CNT_W-1:0] sd_dly_cyc;
		logic [CNT_W-1:0] sd_hold_cyc;
		logic [CNT_W-1:0] pg_cnt_r;
		logic [6:0]       ref_r;
		logic [6:0]       ref_nxt;
		logic [3:0]       margin;
		logic             drv_nxt;
		logic             in_win;
		logic             wr_ch;
		logic             clr_fault;

		assign wr_ch     = i_reg_req.wr && (idx == 4'(g));
		assign clr_fault = misc_wr && (idx == IX_OC_FW) && i_reg_req.wdata[OC_FAULT_LSB + g];

		always_ff @(posedge i_clk_sys)
		begin
			if (!i_rst_b)
			begin
				cur_limit_r[g] <= RST_CUR_LIMIT;
				ss_timing_r[g] <= RST_SEQ;
				sd_timing_r[g] <= RST_SEQ;
				good_up_r[g]   <= RST_GOOD_UP;
				good_lo_r[g]   <= RST_GOOD_LO;
				good_dly_r[g]  <= RST_GOOD_DLY;
				duty_lim_r[g]  <= RST_DUTY_LIM;
			end
			else if (wr_ch)
			begin
				case (page)
					PG_CUR_LIMIT: cur_limit_r[g] <= i_reg_req.wdata[7:0];
					PG_SS_TIMING: ss_timing_r[g] <= i_reg_req.wdata;
					PG_SD_TIMING: sd_timing_r[g] <= i_reg_req.wdata;
					PG_GOOD_UP:   good_up_r[g]   <= i_reg_req.wdata[7:0];
					PG_GOOD_LO:   good_lo_r[g]   <= i_reg_req.wdata[7:0];
					PG_GOOD_DLY:  good_dly_r[g]  <= i_reg_req.wdata[7:0];
					PG_DUTY_LIM:  duty_lim_r[g]  <= i_reg_req.wdata[7:0];
					default:      ;
				endcase
			end
		end

		// Overcurrent compare: threshold in 5 mV steps, margin in 10 mV steps
		assign margin = (4'(cur_limit_r[g][LIM_MARGIN_LSB +: 2]) + 4'h1) * MARGIN_STEP_CODE;
		assign fault_det[g] = (st_r == ST_SS_RAMP || st_r == ST_ON ||
			st_r == ST_SD_DLY || st_r == ST_SD_RAMP) &&
			(i_meas[g].isense > {1'b0, cur_limit_r[g][LIM_THR_LSB +: 6]});

		// Level flag: follows the compare, so it drops without host action
		always_ff @(posedge i_clk_sys)
		begin
			if (!i_rst_b)
				o_oc_warn[g] <= 1'b0;
			else
				o_oc_warn[g] <= ({1'b0, i_meas[g].isense} + {4'h0, margin}) >=
					{2'b00, cur_limit_r[g][LIM_THR_LSB +: 6]};
		end

		// New fault wins over a clear in the same cycle
		always_ff @(posedge i_clk_sys)
		begin
			if (!i_rst_b)
				o_oc_fault[g] <= 1'b0;
			else
				o_oc_fault[g] <= (o_oc_fault[g] & ~clr_fault) | fault_det[g];
		end

		assign ss_dly_cyc  = CNT_W'(ss_timing_r[g][SEQ_DLY_LSB +: 6]) * CNT_W'(SEQ_UNIT_CYC);
		assign ss_hold_cyc = CNT_W'(ss_timing_r[g][SEQ_HOLD_LSB +: 10]) * CNT_W'(US_CYC);
		assign sd_dly_cyc  = CNT_W'(sd_timing_r[g][SEQ_DLY_LSB +: 6]) * CNT_W'(SEQ_UNIT_CYC);
		assign sd_hold_cyc = CNT_W'(sd_timing_r[g][SEQ_HOLD_LSB +: 10]) * CNT_W'(US_CYC);

		// ------------------------------------------------------------
		// Channel sequencer
		// ------------------------------------------------------------
		always_comb
		begin
			st_nxt  = st_r;
			cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
			ref_nxt = ref_r;
			case (st_r)
				ST_OFF:
				begin
					ref_nxt = DISCHARGE_CODE;
					if (chan_en_r[g])
					begin
						st_nxt  = ST_SS_DLY;
						cnt_nxt = ss_dly_cyc;
					end
				end
				ST_SS_DLY:
				begin
					if (!chan_en_r[g])
						st_nxt = ST_OFF;
					else if (cnt_r == '0)
					begin
						st_nxt  = ST_SS_RAMP;
						cnt_nxt = ss_hold_cyc;
					end
				end
				ST_SS_RAMP:
				begin
					if (!chan_en_r[g])
					begin
						st_nxt  = ST_SD_DLY;
						cnt_nxt = sd_dly_cyc;
					end
					else if (cnt_r == '0)
					begin
						if (ref_r >= i_meas[g].vtarget)
							st_nxt = ST_ON;
						else
						begin
							ref_nxt = ref_r + 7'h01;
							cnt_nxt = ss_hold_cyc;
						end
					end
				end
				ST_ON:
				begin
					ref_nxt = i_meas[g].vtarget;
					if (!chan_en_r[g])
					begin
						st_nxt  = ST_SD_DLY;
						cnt_nxt = sd_dly_cyc;
					end
				end
				ST_SD_DLY:
				begin
					if (cnt_r == '0)
					begin
						st_nxt  = ST_SD_RAMP;
						cnt_nxt = sd_hold_cyc;
					end
				end
				ST_SD_RAMP:
				begin
					if (cnt_r == '0)
					begin
						if (ref_r <= DISCHARGE_CODE)
							st_nxt = ST_OFF;
						else
						begin
							ref_nxt = ref_r - 7'h01;
							cnt_nxt = sd_hold_cyc;
						end
					end
				end
				ST_OC_WAIT:
				begin
					if (cnt_r == '0)
					begin
						st_nxt  = chan_en_r[g] ? ST_SS_DLY : ST_OFF;
						cnt_nxt = ss_dly_cyc;
					end
				end
				default:
				begin
					st_nxt = ST_OFF;
				end
			endcase
			if (trig[g] && st_r != ST_OFF && st_r != ST_OC_WAIT)
			begin
				st_nxt  = ST_OC_WAIT;
				cnt_nxt = CNT_W'(OC_RESTART_CYCLES - 1);
				ref_nxt = DISCHARGE_CODE;
			end
		end

		assign drv_nxt = freq_ok && (st_nxt == ST_SS_RAMP || st_nxt == ST_ON ||
			st_nxt == ST_SD_DLY || st_nxt == ST_SD_RAMP);

		always_ff @(posedge i_clk_sys)
		begin
			if (!i_rst_b)
			begin
				st_r          <= ST_OFF;
				cnt_r         <= '0;
				ref_r         <= DISCHARGE_CODE;
				o_drv_en[g]   <= 1'b0;
				o_ref_code[g] <= DISCHARGE_CODE;
			end
			else
			begin
				st_r          <= st_nxt;
				cnt_r         <= cnt_nxt;
				ref_r         <= ref_nxt;
				o_drv_en[g]   <= drv_nxt;
				o_ref_code[g] <= ref_nxt;
			end
		end

		// ------------------------------------------------------------
		// Power good
		// ------------------------------------------------------------
		assign in_win = (i_meas[g].vout >= good_lo_r[g]) && (i_meas[g].vout <= good_up_r[g]);

		always_ff @(posedge i_clk_sys)
		begin
			if (!i_rst_b)
			begin
				pg_cnt_r   <= '0;
				o_pgood[g] <= 1'b0;
			end
			else
			begin
				if (st_r != ST_ON)
					pg_cnt_r <= CNT_W'(good_dly_r[g]) * CNT_W'(SEQ_UNIT_CYC);
				else if (pg_cnt_r != '0)
					pg_cnt_r <= pg_cnt_r - 1'b1;
				o_pgood[g] <= (st_r == ST_ON) && (pg_cnt_r == '0) && in_win;
			end
		end

		bcs_pwm u_pwm (
			.i_clk_sys  (i_clk_sys),
			.i_rst_b    (i_rst_b),
			.i_run      (drv_nxt),
			.i_osc      (freq_r[FREQ_OSC_LSB +: 3]),
			.i_div      (freq_r[FREQ_DIV_LSB +: 3]),
			.i_duty_cmd (i_meas[g].duty_cmd),
			.i_duty_lim (duty_lim_r[g]),
			.o_hi       (o_pwm_hi[g])
		);
	end

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	// Unmapped addresses and channels beyond NCH read as zero
	always_comb
	begin
		rdata_nxt = 16'h0000;
		if (page == PG_MISC)
		begin
			case (idx)
				IX_FREQ:      rdata_nxt = {8'h00, freq_r};
				IX_FOLLOW_LO: rdata_nxt = {8'h00, follow_lo_r};
				IX_FOLLOW_HI: rdata_nxt = {8'h00, follow_hi_r};
				IX_CHAN_EN:   rdata_nxt[NCH-1:0] = chan_en_r;
				IX_OC_FLAG:   rdata_nxt[NCH-1:0] = o_oc_warn;
				IX_OC_FW:
				begin
					rdata_nxt[NCH-1:0] = o_oc_warn;
					rdata_nxt[OC_FAULT_LSB +: NCH] = o_oc_fault;
				end
				IX_PG_STAT:   rdata_nxt[NCH-1:0] = o_pgood;
				default:      rdata_nxt = 16'h0000;
			endcase
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (idx == 4'(c))
				begin
					case (page)
						PG_CUR_LIMIT: rdata_nxt = {8'h00, cur_limit_r[c]};
						PG_SS_TIMING: rdata_nxt = ss_timing_r[c];
						PG_SD_TIMING: rdata_nxt = sd_timing_r[c];
						PG_GOOD_UP:   rdata_nxt = {8'h00, good_up_r[c]};
						PG_GOOD_LO:   rdata_nxt = {8'h00, good_lo_r[c]};
						PG_GOOD_DLY:  rdata_nxt = {8'h00, good_dly_r[c]};
						PG_DUTY_LIM:  rdata_nxt = {8'h00, duty_lim_r[c]};
						default:      rdata_nxt = 16'h0000;
					endcase
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			o_reg_rdata  <= 16'h0000;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_req.rd;
			if (i_reg_req.rd)
				o_reg_rdata <= rdata_nxt;
		end
	end

endmodule
`default_nettype wire

/* File: common/bcs_pkg.sv */
// Shared constants, types and helpers for the buck channel sequencer
package bcs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 10_000_000;
	localparam int US_CYC          = CLK_HZ / 1_000_000;
	localparam int SEQ_UNIT_US     = 250;
	localparam int SEQ_UNIT_CYC    = SEQ_UNIT_US * US_CYC;
	localparam int OC_RESTART_MS   = 200;
	localparam int OC_RESTART_CYC  = OC_RESTART_MS * 1000 * US_CYC;
	localparam int MIN_ON_PS       = 40_000;
	localparam int CNT_W           = 24;
	localparam int NCH_DEF         = 4;
	localparam int FOLLOW_W        = 4;

	// ----------------------------------------------------------------
	// Register map: page in address[7:4], channel or index in [3:0]
	// ----------------------------------------------------------------
	localparam logic [3:0] PG_CUR_LIMIT = 4'h1;
	localparam logic [3:0] PG_SS_TIMING = 4'h2;
	localparam logic [3:0] PG_SD_TIMING = 4'h3;
	localparam logic [3:0] PG_GOOD_UP   = 4'h4;
	localparam logic [3:0] PG_GOOD_LO   = 4'h5;
	localparam logic [3:0] PG_GOOD_DLY  = 4'h6;
	localparam logic [3:0] PG_DUTY_LIM  = 4'h7;
	localparam logic [3:0] PG_MISC      = 4'h8;
	localparam logic [3:0] IX_FREQ      = 4'h0;
	localparam logic [3:0] IX_FOLLOW_LO = 4'h1;
	localparam logic [3:0] IX_FOLLOW_HI = 4'h2;
	localparam logic [3:0] IX_CHAN_EN   = 4'h3;
	localparam logic [3:0] IX_OC_FLAG   = 4'h4;
	localparam logic [3:0] IX_OC_FW     = 4'h5;
	localparam logic [3:0] IX_PG_STAT   = 4'h6;

	// ----------------------------------------------------------------
	// Field positions and scaling
	// ----------------------------------------------------------------
	localparam int LIM_THR_LSB     = 0;
	localparam int LIM_MARGIN_LSB  = 6;
	localparam int SEQ_DLY_LSB     = 10;
	localparam int SEQ_HOLD_LSB    = 0;
	localparam int FREQ_OSC_LSB    = 4;
	localparam int FREQ_DIV_LSB    = 0;
	localparam int OC_FAULT_LSB    = 4;
	localparam int CUR_LSB_MV      = 5;
	localparam int MARGIN_STEP_MV  = 10;
	localparam logic [3:0] MARGIN_STEP_CODE = 4'(MARGIN_STEP_MV / CUR_LSB_MV);
	localparam int PERIOD_MULT     = 16;
	localparam int DUTY_SHIFT      = 8;
	localparam logic [6:0] DISCHARGE_CODE = 7'h00;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_CUR_LIMIT = 8'h3F;
	localparam logic [15:0] RST_SEQ       = 16'h0000;
	localparam logic [7:0]  RST_GOOD_UP   = 8'hFF;
	localparam logic [7:0]  RST_GOOD_LO   = 8'h00;
	localparam logic [7:0]  RST_GOOD_DLY  = 8'h00;
	localparam logic [7:0]  RST_DUTY_LIM  = 8'hC7;
	localparam logic [7:0]  RST_FREQ      = 8'h01;
	localparam logic [7:0]  RST_FOLLOW    = 8'h00;

	// Main oscillator period per code, in picoseconds
	localparam int TS_PS [8] = '{20800, 22300, 24000, 26000, 28400, 31250, 34700, 39000};

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_SS_DLY  = 3'b001,
		ST_SS_RAMP = 3'b010,
		ST_ON      = 3'b011,
		ST_SD_DLY  = 3'b100,
		ST_SD_RAMP = 3'b101,
		ST_OC_WAIT = 3'b110
	} bcs_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} bcs_reg_req_t;

	typedef struct packed {
		logic [6:0] isense;
		logic [7:0] vout;
		logic [6:0] vtarget;
		logic [7:0] duty_cmd;
	} bcs_meas_t;

	function automatic logic [7:0] min_on_cycles(input logic [2:0] osc);
		int ts;
		ts = TS_PS[osc];
		return 8'((MIN_ON_PS + ts - 1) / ts);
	endfunction

	function automatic logic freq_valid(input logic [2:0] osc, input logic [2:0] div);
		return !((div == 3'h0) || (div == 3'h5 && osc == 3'h7) ||
			(div == 3'h6 && osc >= 3'h5) || (div == 3'h7 && osc >= 3'h4));
	endfunction

endpackage

/* File: rtl/bcs_pwm.sv */
// Per-channel switching pulse generator with duty clamp and minimum on time
`timescale 1ns/10ps
`default_nettype none

module bcs_pwm
	import bcs_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic       i_run,
	input  wire logic [2:0] i_osc,
	input  wire logic [2:0] i_div,
	input  wire logic [7:0] i_duty_cmd,
	input  wire logic [7:0] i_duty_lim,
	output logic            o_hi
);

	logic [7:0]  period;
	logic [7:0]  duty_eff;
	logic [15:0] prod;
	logic [7:0]  on_cyc;
	logic [7:0]  min_on;
	logic [7:0]  ph_r;
	logic [7:0]  ph_nxt;
	logic [7:0]  on_r;

	assign period   = 8'(PERIOD_MULT) * (8'(i_div) + 8'h01);
	assign duty_eff = (i_duty_cmd > i_duty_lim) ? i_duty_lim : i_duty_cmd;
	assign prod     = 16'(duty_eff) * 16'(period);
	assign min_on   = min_on_cycles(i_osc);
	assign on_cyc   = (prod[15:DUTY_SHIFT] < min_on) ? min_on : prod[15:DUTY_SHIFT];
	assign ph_nxt   = (ph_r >= period - 8'h01) ? 8'h00 : ph_r + 8'h01;

	// ----------------------------------------------------------------
	// Phase counter; on time is taken only at period start
	// ----------------------------------------------------------------
	// Latching per period avoids runt pulses when the command moves mid-cycle
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b || !i_run)
		begin
			ph_r <= 8'h00;
			on_r <= 8'h00;
			o_hi <= 1'b0;
		end
		else
		begin
			ph_r <= ph_nxt;
			if (ph_nxt == 8'h00)
			begin
				on_r <= on_cyc;
				o_hi <= 1'b1;
			end
			else
			begin
				o_hi <= (ph_nxt < on_r);
			end
		end
	end

endmodule
`default_nettype wire

/* File: tb/bcs_top_monitor.sv */
// Assertion checker bound to the sequencer top ports
`timescale 1ns/10ps
`default_nettype none
module bcs_top_monitor
	import bcs_pkg::*;
#(
	parameter int NCH               = 4,
	parameter int OC_RESTART_CYCLES = 50
)
(
	input wire logic                         i_clk_sys,
	input wire logic                         i_rst_b,
	input wire bcs_pkg::bcs_reg_req_t        i_reg_req,
	input wire bcs_pkg::bcs_meas_t [NCH-1:0] i_meas,
	input wire logic [15:0]                  o_reg_rdata,
	input wire logic                         o_reg_rvalid,
	input wire logic [NCH-1:0]               o_pwm_hi,
	input wire logic [NCH-1:0]               o_drv_en,
	input wire logic [NCH-1:0]               o_pgood,
	input wire logic [NCH-1:0]               o_oc_warn,
	input wire logic [NCH-1:0]               o_oc_fault,
	input wire logic [2:0]                   o_osc_sel,
	input wire logic [NCH-1:0][6:0]          o_ref_code
);
	// ------------------------------------------------
	// Register shadows, channel 0 only to keep it cheap
	// ------------------------------------------------
	logic [7:0]  lim_r, up_r, lo_r, duty_r, fol_r, fr_r;
	logic [31:0] oc_cnt_r;
	logic [9:0]  hi_len_r;
	wire  [7:0]  wsum     = {1'b0, i_meas[0].isense} + {5'd0, lim_r[7:6], 1'b0} + 8'd2;
	wire         warn_now = wsum >= {2'b0, lim_r[5:0]};
	wire         trip     = o_drv_en[0] && (i_meas[0].isense > {1'b0, lim_r[5:0]});
	wire         in_win   = i_meas[0].vout >= lo_r && i_meas[0].vout <= up_r;
	wire  [15:0] prd      = ({13'd0, fr_r[2:0]} + 16'd1) << 4;
	wire  [15:0] on_max   = (16'(duty_r) * prd) >> 8;
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			lim_r  <= RST_CUR_LIMIT;
			up_r   <= RST_GOOD_UP;
			lo_r   <= RST_GOOD_LO;
			duty_r <= RST_DUTY_LIM;
			fol_r  <= RST_FOLLOW;
			fr_r   <= RST_FREQ;
		end
		else if (i_reg_req.wr)
		begin
			case (i_reg_req.addr)
				8'h10: lim_r <= i_reg_req.wdata[7:0];
				8'h40: up_r <= i_reg_req.wdata[7:0];
				8'h50: lo_r <= i_reg_req.wdata[7:0];
				8'h70: duty_r <= i_reg_req.wdata[7:0];
				8'h80: fr_r <= i_reg_req.wdata[7:0];
				8'h81: fol_r <= i_reg_req.wdata[7:0];
				default: ;
			endcase
		end
	end
	// Restart wait runs far longer than a repetition may, so count it
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			oc_cnt_r <= '0;
		else if (trip)
			oc_cnt_r <= 32'd1;
		else if (oc_cnt_r != 0)
			oc_cnt_r <= (oc_cnt_r >= OC_RESTART_CYCLES - 1) ? '0 : oc_cnt_r + 32'd1;
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b || !o_pwm_hi[0])
			hi_len_r <= '0;
		else
			hi_len_r <= hi_len_r + 10'd1;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	sequence s_trip;
		trip;
	endsequence
	sequence s_pulse_end;
		$fell(o_pwm_hi[0]);
	endsequence
	property p_warn;
		$past(i_rst_b) |-> o_oc_warn[0] == $past(warn_now);
	endproperty
	property p_oc_stop;
		s_trip |=> !o_drv_en[0] && !o_pwm_hi[0] && o_oc_fault[0] && o_ref_code[0] == 7'h00;
	endproperty
	property p_oc_wait;
		oc_cnt_r != 0 |-> !o_drv_en[0];
	endproperty
	property p_follow;
		s_trip ##0 fol_r[1] |=> !o_drv_en[1] && o_ref_code[1] == 7'h00;
	endproperty
	property p_pg_win;
		o_pgood[0] && $past(i_rst_b) |-> $past(in_win);
	endproperty
	property p_pg_drv;
		o_pgood[0] |-> $past(o_drv_en[0]);
	endproperty
	property p_osc;
		i_reg_req.wr && i_reg_req.addr == 8'h80 |=> ##1 o_osc_sel == $past(fr_r[6:4]);
	endproperty
	property p_min_on;
		s_pulse_end ##0 o_drv_en[0] |-> hi_len_r >= 10'd2;
	endproperty
	property p_max_on;
		s_pulse_end |-> {6'd0, hi_len_r} <= on_max || hi_len_r == 10'd2;
	endproperty
	property p_rd;
		i_reg_req.rd && i_reg_req.addr == 8'h10 |=> o_reg_rvalid && o_reg_rdata == {8'h00, $past(lim_r)};
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag wrong");
	a_oc_stop: assert property (p_oc_stop) else $error("fault did not stop channel");
	a_oc_wait: assert property (p_oc_wait) else $error("restart too early");
	a_follow: assert property (p_follow) else $error("follower kept running");
	a_pg_win: assert property (p_pg_win) else $error("power good outside window");
	a_pg_drv: assert property (p_pg_drv) else $error("power good before start done");
	a_osc: assert property (p_osc) else $error("oscillator code wrong");
	a_min_on: assert property (p_min_on) else $error("pulse too short");
	a_max_on: assert property (p_max_on) else $error("pulse over duty limit");
	a_rd: assert property (p_rd) else $error("limit readback wrong");
endmodule
bind bcs_top bcs_top_monitor #(.NCH(NCH), .OC_RESTART_CYCLES(OC_RESTART_CYCLES)) u_mon (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_req(i_reg_req), .i_meas(i_meas),
	.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_pwm_hi(o_pwm_hi),
	.o_drv_en(o_drv_en), .o_pgood(o_pgood), .o_oc_warn(o_oc_warn), .o_oc_fault(o_oc_fault),
	.o_osc_sel(o_osc_sel), .o_ref_code(o_ref_code));
`default_nettype wire

/* File: tb/bcs_stage_model.sv */
// Power stage model: output voltage follows the reference while driven
`timescale 1ns/10ps
`default_nettype none
module bcs_stage_model
	import bcs_pkg::*;
#(
	parameter int NCH = 4
)
(
	input  wire logic [NCH-1:0]          i_drv_en,
	input  wire logic [NCH-1:0][6:0]     i_ref_code,
	input  wire logic [NCH-1:0][6:0]     i_isense,
	input  wire logic [NCH-1:0][7:0]     i_vpre,
	input  wire logic [7:0]              i_duty,
	output var bcs_pkg::bcs_meas_t [NCH-1:0] o_meas
);
	// Undriven rail keeps its precharge level, no ideal discharge
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			o_meas[c].isense   = i_isense[c];
			o_meas[c].vout     = i_drv_en[c] ? 8'((16'(i_ref_code[c]) * 16'd5) >> 1) : i_vpre[c];
			o_meas[c].vtarget  = 7'h03;
			o_meas[c].duty_cmd = i_duty;
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_buck_channel_sequencer_protection.sv */
// Self-checking bench for the buck channel sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module test_buck_channel_sequencer_protection;
	import bcs_pkg::*;
	localparam int NCH = 4;
	localparam int OCW = 50;
	logic                clk_sys = 1'b0;
	logic                rst_b;
	bcs_reg_req_t        req;
	logic [NCH-1:0][6:0] isense, ref_c;
	logic [NCH-1:0][7:0] vpre;
	logic [7:0]          duty;
	bcs_meas_t [NCH-1:0] meas;
	logic [15:0]         rdata, d;
	logic                rvalid;
	logic [NCH-1:0]      pwm, drv, pg, warn, flt;
	logic [2:0]          osc;
	int                  mismatches, checks_done, seed, i, m, v;
	bcs_top #(.NCH(NCH), .OC_RESTART_CYCLES(OCW)) DUT (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
		.i_reg_req(req), .i_meas(meas), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_pwm_hi(pwm), .o_drv_en(drv), .o_pgood(pg), .o_oc_warn(warn), .o_oc_fault(flt),
		.o_osc_sel(osc), .o_ref_code(ref_c));
	bcs_stage_model #(.NCH(NCH)) u_stage (.i_drv_en(drv), .i_ref_code(ref_c),
		.i_isense(isense), .i_vpre(vpre), .i_duty(duty), .o_meas(meas));
	always #50 clk_sys = ~clk_sys;
	// ------------------------------------------------
	// Bus and helper tasks
	// ------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] x);
		@(posedge clk_sys);
		req.wr    <= 1'b1;
		req.addr  <= a;
		req.wdata <= x;
		@(posedge clk_sys);
		req.wr    <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		req.rd   <= 1'b1;
		req.addr <= a;
		@(posedge clk_sys);
		req.rd   <= 1'b0;
		#1;
		`CHK(rvalid, 1'b1)
		d = rdata;
		`CHK(d, e)
	endtask
	task automatic set_cur(input int ch, input int x);
		@(posedge clk_sys);
		isense[ch] <= 7'(x);
	endtask
	task automatic wait_drv(input int ch, input logic x, input int lim);
		int n;
		n = 0;
		while (drv[ch] !== x && n < lim)
		begin
			cyc(1);
			n++;
		end
		`CHK(drv[ch], x)
	endtask
	function automatic logic exp_warn(input int cur, input int mg, input int thr);
		return cur * CUR_LSB_MV + MARGIN_STEP_MV * (mg + 1) >= thr * CUR_LSB_MV;
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		stop_test();
	end
	initial
	begin
		seed = 42472;
		rst_b = 1'b0;
		req = '0;
		isense = '0;
		vpre = '0;
		duty = 8'h80;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd_chk(8'h10, 16'h003F);
		rd_chk(8'h70, 16'h00C7);
		rd_chk(8'h80, 16'h0001);
		rd_chk(8'h40, 16'h00FF);
		rd_chk(8'h9F, 16'h0000);
		reg_wr(8'h50, 16'h0005);
		reg_wr(8'h40, 16'h0009);
		rd_chk(8'h50, 16'h0005);
		for (i = 0; i < 8; i++)
		begin
			reg_wr(8'h80, 16'(i * 16 + 1));
			cyc(2);
			`CHK(osc, 3'(i))
		end
		// Threshold stays at 20 while the margin field steps through all four codes
		for (m = 0; m < 4; m++)
		begin
			reg_wr(8'h10, 16'(m * 64 + 20));
			for (i = 0; i < 4; i++)
			begin
				v = (i < 2) ? 20 - i - 2 * (m + 1) : {$random(seed)} % 21;
				set_cur(0, v);
				cyc(3);
				`CHK(warn[0], exp_warn(v, m, 20))
			end
		end
		reg_wr(8'h10, 16'h0030);
		set_cur(0, 0);
		reg_wr(8'h80, 16'h0075);
		reg_wr(8'h23, 16'h0001);
		reg_wr(8'h83, 16'h0008);
		cyc(100);
		`CHK({drv[3], pwm[3]}, 2'b00)
		reg_wr(8'h83, 16'h0000);
		reg_wr(8'h80, 16'h0001);
		reg_wr(8'h20, 16'h0402);
		reg_wr(8'h21, 16'h0001);
		reg_wr(8'h60, 16'h0001);
		reg_wr(8'h81, 16'h0002);
		@(posedge clk_sys);
		vpre[0] <= 8'h07;
		reg_wr(8'h83, 16'h0003);
		cyc(2400);
		`CHK({drv[0], pg[0], ref_c[0]}, 9'h000)
		wait_drv(0, 1'b1, 200);
		cyc(30);
		`CHK(ref_c[0] < 7'h03, 1'b1)
		cyc(60);
		`CHK(ref_c[0], 7'h03)
		cyc(1000);
		`CHK(pg[0], 1'b0)
		cyc(1700);
		`CHK(pg[0], 1'b1)
		reg_wr(8'h50, 16'h0008);
		cyc(3);
		`CHK(pg[0], 1'b0)
		reg_wr(8'h50, 16'h0005);
		cyc(3);
		`CHK(pg[0], 1'b1)
		rd_chk(8'h86, 16'h0003);
		for (i = 0; i < 12; i++)
		begin
			@(posedge clk_sys);
			duty <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			cyc(70);
		end
		set_cur(0, 49);
		cyc(2);
		`CHK({drv[1:0], flt[0]}, 3'b001)
		rd_chk(8'h85, 16'h0011);
		rd_chk(8'h84, 16'h0001);
		set_cur(0, 0);
		cyc(35);
		`CHK(drv[0], 1'b0)
		wait_drv(0, 1'b1, 2700);
		`CHK(drv[1], 1'b1)
		reg_wr(8'h85, 16'h0010);
		rd_chk(8'h85, 16'h0000);
		`CHK(d[4], 1'b0)
		reg_wr(8'h30, 16'h0401);
		cyc(100);
		reg_wr(8'h83, 16'h0002);
		cyc(2400);
		`CHK({drv[0], ref_c[0]}, 8'h83)
		wait_drv(0, 1'b0, 300);
		`CHK(ref_c[0], 7'h00)
		stop_test();
	end
endmodule
`default_nettype wire
